// file: rhg_defs.svh
// Purpose: offsets, field positions, reset values and table codes for the receive global configuration block
// Assumes: 32-bit register words at byte offsets
// Notes:   included by rhg_pkg and the top module
`ifndef RHG_DEFS_SVH
`define RHG_DEFS_SVH
`define RHG_OFF_HDLC_CFG     12'h220
`define RHG_OFF_MAX_LEN      12'h224
`define RHG_OFF_DMA_CTRL     12'h280
`define RHG_CFG_LENGTH_CHECK_ENABLE_BIT   9
`define RHG_CFG_ORDER_BIT    8
`define RHG_CFG_RESV_MSB     2
`define RHG_CFG_RESET        32'h0000_0007
`define RHG_CFG_MASK         32'h0000_0307
`define RHG_MAX_RESET        32'h0000_FFFF
`define RHG_MAX_MASK         32'h0000_FFFF
`define RHG_CTL_RESET        32'h0000_001E
`define RHG_CTL_MASK         32'h0000_0FFF
`define RHG_CTL_ENABLE_BIT   0
`define RHG_CTL_LARGE_BUFFER_CACHE_ENABLE_BIT   1
`define RHG_CTL_SMALL_BUFFER_CACHE_ENABLE_BIT   2
`define RHG_CTL_RAW_LSB      3
`define RHG_CTL_RDY_LSB      5
`define RHG_CTL_LF_LSB       8
`define RHG_CTL_SF_LSB       10
`define RHG_CACHE_BURST      3'h6
`endif

// file: rhg_pkg.sv
// Purpose: shared types for the receive global configuration block
// Assumes: constants come from rhg_defs.svh
// Notes:   none
`include "rhg_defs.svh"
package rhg_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        sop;
    logic        eop;
  } rhg_word_t;
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } rhg_reg_req_t;
  typedef enum logic [1:0] {RHG_IDLE, RHG_PASS, RHG_DROP} rhg_state_t;
endpackage : rhg_pkg

// file: rhg_top.sv
// Purpose: global receive configuration registers and the logic they steer
// Assumes: register port and stream inputs synchronous to clock; 10 MHz
// Notes:   register reads return next cycle; bytes arrive lsb-first in rx word
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - writes update whole word; no enables no-op
// - clear order: first bit on byte lsb
// - set order: first bit on byte msb
// - length check aborts over-long packets, drops rest
// - check off never aborts; max all ones
// - whole packet counted, abort strictly longer
// - order and check shared by all channels
// - enable gates accepting and writing data
// - large cache fetches up to six
// - small cache fetches up to six
// - raw chain posted after count plus one
// - ready irq after 1,4,6,8,16,32 postings
// - large free irq after 1,4,8 reads
// - small free irq after 1,4,8 reads
`timescale 1ns/10ps
`include "rhg_defs.svh"
module rhg_top (
  input  wire logic                 clock,          // system clock
  input  wire logic                 resetn,         // async reset, low
  input  wire rhg_pkg::rhg_reg_req_t reg_req,       // register access
  output logic [31:0]               reg_rdata,      // read data
  input  wire rhg_pkg::rhg_word_t   rx_in,          // word from hdlc processor
  output logic                      rx_ready,       // engine accepts words
  output rhg_pkg::rhg_word_t        host_out,       // word toward host memory
  output logic                      pkt_abort,      // length abort pulse
  input  wire logic                 raw_buf_done,   // raw buffer filled
  output logic                      raw_chain_post, // raw chain to ready queue
  input  wire logic                 rdy_post,       // reference posted
  input  wire logic                 lf_read,        // large free block read
  input  wire logic                 sf_read,        // small free block read
  output logic [2:0]                lf_burst,       // large fetch size
  output logic [2:0]                sf_burst,       // small fetch size
  output logic                      ready_queue_irq,      // ready threshold met
  output logic                      large_free_queue_irq, // large threshold met
  output logic                      small_free_queue_irq  // small threshold met
);
  import rhg_pkg::*;

  function automatic logic [5:0] thr2(input logic [1:0] c);
    // reserved code acts as largest
    case (c)
      2'h0:    thr2 = 6'h01;
      2'h1:    thr2 = 6'h04;
      default: thr2 = 6'h08;
    endcase
  endfunction : thr2

  function automatic logic [31:0] order(input logic [31:0] w, input logic rev);
    order = w;
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < 8; i++) begin
        if (rev) order[b*8+i] = w[b*8+7-i];
      end
    end
  endfunction : order

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [31:0] cfg_r, cfg_nxt, max_r, max_nxt, ctl_r, ctl_nxt, rd_nxt;
  logic        wr_go;
  always_comb begin
    cfg_nxt = cfg_r;
    max_nxt = max_r;
    ctl_nxt = ctl_r;
    rd_nxt  = 32'h0000_0000;
    wr_go   = reg_req.req && reg_req.wr && (reg_req.be_n != 4'hF);
    if (reg_req.addr == `RHG_OFF_HDLC_CFG) begin
      if (wr_go) cfg_nxt = reg_req.wdata & `RHG_CFG_MASK;
      rd_nxt = cfg_r;
    end else if (reg_req.addr == `RHG_OFF_MAX_LEN) begin
      if (wr_go) max_nxt = reg_req.wdata & `RHG_MAX_MASK;
      rd_nxt = max_r;
    end else if (reg_req.addr == `RHG_OFF_DMA_CTRL) begin
      if (wr_go) ctl_nxt = reg_req.wdata & `RHG_CTL_MASK;
      rd_nxt = ctl_r;
    end
    if (!(reg_req.req && !reg_req.wr && reg_req.be_n != 4'hF)) rd_nxt = 32'h0000_0000;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_r     <= `RHG_CFG_RESET;
      max_r     <= `RHG_MAX_RESET;
      ctl_r     <= `RHG_CTL_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      cfg_r     <= cfg_nxt;
      max_r     <= max_nxt;
      ctl_r     <= ctl_nxt;
      reg_rdata <= rd_nxt;
    end
  end

  logic       en, lchk, rev;
  logic [1:0] raw_max;
  assign en      = ctl_r[`RHG_CTL_ENABLE_BIT];
  assign lchk    = cfg_r[`RHG_CFG_LENGTH_CHECK_ENABLE_BIT];
  assign rev     = cfg_r[`RHG_CFG_ORDER_BIT];
  assign raw_max = ctl_r[`RHG_CTL_RAW_LSB +: 2];

  //------------------------------------------------------------
  // data path, one setting for every channel
  //------------------------------------------------------------
  rhg_state_t st_r, st_nxt;
  logic [16:0] len_r, len_nxt, len_inc;
  rhg_word_t   out_nxt;
  logic        abort_nxt;
  always_comb begin
    st_nxt    = st_r;
    len_nxt   = len_r;
    out_nxt   = '0;
    abort_nxt = 1'b0;
    len_inc   = (rx_in.sop ? 17'h0 : len_r) + 17'h4;
    if (en && rx_in.valid) begin
      case (st_r)
        RHG_IDLE, RHG_PASS: begin
          if (lchk && len_inc > {1'b0, max_r[15:0]}) begin
            abort_nxt = 1'b1;
            st_nxt    = rx_in.eop ? RHG_IDLE : RHG_DROP;
            len_nxt   = 17'h0;
          end else begin
            out_nxt       = rx_in;
            out_nxt.data  = order(rx_in.data, rev);
            len_nxt       = rx_in.eop ? 17'h0 : len_inc;
            st_nxt        = rx_in.eop ? RHG_IDLE : RHG_PASS;
          end
        end
        RHG_DROP: begin
          if (rx_in.eop) st_nxt = RHG_IDLE;
        end
        default: st_nxt = RHG_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r      <= RHG_IDLE;
      len_r     <= 17'h0;
      host_out  <= '0;
      pkt_abort <= 1'b0;
      rx_ready  <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      len_r     <= len_nxt;
      host_out  <= out_nxt;
      pkt_abort <= abort_nxt;
      rx_ready  <= ctl_nxt[`RHG_CTL_ENABLE_BIT];
    end
  end

  //------------------------------------------------------------
  // queue counters and thresholds
  //------------------------------------------------------------
  logic [5:0] rdy_r, rdy_nxt, lf_r, lf_nxt, sf_r, sf_nxt, rdy_thr;
  logic [1:0] raw_r, raw_nxt;
  logic       rdy_hit, lf_hit, sf_hit, raw_hit;
  always_comb begin
    case (ctl_r[`RHG_CTL_RDY_LSB +: 3])
      3'h0:    rdy_thr = 6'h01;
      3'h1:    rdy_thr = 6'h04;
      3'h2:    rdy_thr = 6'h06;
      3'h3:    rdy_thr = 6'h08;
      3'h4:    rdy_thr = 6'h10;
      default: rdy_thr = 6'h20;
    endcase
    rdy_hit = en && rdy_post && (rdy_r + 6'h1 >= rdy_thr);
    lf_hit  = en && lf_read && (lf_r + 6'h1 >= thr2(ctl_r[`RHG_CTL_LF_LSB +: 2]));
    sf_hit  = en && sf_read && (sf_r + 6'h1 >= thr2(ctl_r[`RHG_CTL_SF_LSB +: 2]));
    raw_hit = en && raw_buf_done && (raw_r >= raw_max);
    rdy_nxt = rdy_hit ? 6'h0 : rdy_r + {5'h0, en && rdy_post};
    lf_nxt  = lf_hit ? 6'h0 : lf_r + {5'h0, en && lf_read};
    sf_nxt  = sf_hit ? 6'h0 : sf_r + {5'h0, en && sf_read};
    raw_nxt = raw_hit ? 2'h0 : raw_r + {1'b0, en && raw_buf_done};
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdy_r <= 6'h0;
      lf_r  <= 6'h0;
      sf_r  <= 6'h0;
      raw_r <= 2'h0;
      ready_queue_irq      <= 1'b0;
      large_free_queue_irq <= 1'b0;
      small_free_queue_irq <= 1'b0;
      raw_chain_post       <= 1'b0;
      // both cache bits reset set, so bursts start at six
      lf_burst <= `RHG_CACHE_BURST;
      sf_burst <= `RHG_CACHE_BURST;
    end else begin
      rdy_r <= rdy_nxt;
      lf_r  <= lf_nxt;
      sf_r  <= sf_nxt;
      raw_r <= raw_nxt;
      ready_queue_irq      <= rdy_hit;
      large_free_queue_irq <= lf_hit;
      small_free_queue_irq <= sf_hit;
      raw_chain_post       <= raw_hit;
      lf_burst <= ctl_nxt[`RHG_CTL_LARGE_BUFFER_CACHE_ENABLE_BIT] ? `RHG_CACHE_BURST : 3'h1;
      sf_burst <= ctl_nxt[`RHG_CTL_SMALL_BUFFER_CACHE_ENABLE_BIT] ? `RHG_CACHE_BURST : 3'h1;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  sequence s_wr_cfg_none;
    reg_req.req && reg_req.wr && reg_req.be_n == 4'hF;
  endsequence
  a_no_be_hold: assert property (@(posedge clock) disable iff (!resetn)
    s_wr_cfg_none |=> $stable(cfg_r) && $stable(max_r) && $stable(ctl_r))
    else $error("write with no byte enables changed a register");
  a_disable_quiet: assert property (@(posedge clock) disable iff (!resetn)
    !en |=> !host_out.valid)
    else $error("data moved while disabled");
  a_order_datacom: assert property (@(posedge clock) disable iff (!resetn)
    (en && rx_in.valid && !rev && st_r != RHG_DROP && !abort_nxt) |=> host_out.data == $past(rx_in.data))
    else $error("datacom order altered data");
  a_order_telecom: assert property (@(posedge clock) disable iff (!resetn)
    (en && rx_in.valid && rev && st_r != RHG_DROP && !abort_nxt) |=> host_out.data[7] == $past(rx_in.data[0]))
    else $error("telecom order not reversed");
  a_no_abort_off: assert property (@(posedge clock) disable iff (!resetn)
    !lchk |=> !pkt_abort)
    else $error("abort with length check off");
  a_abort_drops: assert property (@(posedge clock) disable iff (!resetn)
    pkt_abort |-> !host_out.valid)
    else $error("aborted word forwarded");
  a_cache_six: assert property (@(posedge clock) disable iff (!resetn)
    ctl_r[`RHG_CTL_LARGE_BUFFER_CACHE_ENABLE_BIT] |-> lf_burst == 3'h6)
    else $error("large burst not six");
  a_small_single: assert property (@(posedge clock) disable iff (!resetn)
    !ctl_r[`RHG_CTL_SMALL_BUFFER_CACHE_ENABLE_BIT] |-> sf_burst == 3'h1)
    else $error("small burst not one");
  a_irq_restart: assert property (@(posedge clock) disable iff (!resetn)
    ready_queue_irq |-> rdy_r == 6'h0)
    else $error("ready counter not restarted");
  a_lf_one: assert property (@(posedge clock) disable iff (!resetn)
    (en && lf_read && ctl_r[`RHG_CTL_LF_LSB +: 2] == 2'h0) |=> large_free_queue_irq)
    else $error("large free irq missed at one read");
  a_sf_one: assert property (@(posedge clock) disable iff (!resetn)
    (en && sf_read && ctl_r[`RHG_CTL_SF_LSB +: 2] == 2'h0) |=> small_free_queue_irq)
    else $error("small free irq missed at one read");
  a_rdy_one: assert property (@(posedge clock) disable iff (!resetn)
    (en && rdy_post && ctl_r[`RHG_CTL_RDY_LSB +: 3] == 3'h0) |=> ready_queue_irq)
    else $error("ready irq missed at one posting");
  a_raw_single: assert property (@(posedge clock) disable iff (!resetn)
    (en && raw_buf_done && raw_max == 2'h0) |=> raw_chain_post)
    else $error("raw chain not posted");
endmodule : rhg_top

// file: rhg_host.sv
// Purpose: host model that programs the configuration registers
// Assumes: one access at a time, launched on the falling edge
// Notes:   read data is taken in the cycle after the request edge
`timescale 1ns/10ps
`include "rhg_defs.svh"
module rhg_host (
  input  wire logic          clock,     // system clock
  output rhg_pkg::rhg_reg_req_t reg_req, // register access
  input  wire logic [31:0]   reg_rdata  // read data
);
  import rhg_pkg::*;
  initial reg_req = '0;
  // software keeps the low reserved bits at ones on every config write
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    logic [31:0] v;
    v = (a == `RHG_OFF_HDLC_CFG) ? (d | 32'h0000_0007) : d;
    @(negedge clock);
    reg_req = '{req: 1'b1, wr: w, addr: a, be_n: be, wdata: v};
    @(negedge clock);
    reg_req = '0;
    q = reg_rdata;
  endtask : acc
endmodule : rhg_host

// file: rhg_top_tb.sv
// Purpose: self-checking bench for the receive global configuration block
// Assumes: inputs change on the falling edge
// Notes:   event pulses are spaced so each one is counted alone
`timescale 1ns/10ps
`include "rhg_defs.svh"
module rhg_top_tb;
  import rhg_pkg::*;
  logic         clock, resetn, rx_ready, pkt_abort;
  logic [3:0]   ev_in;
  wire  [3:0]   ev_out;
  logic [2:0]   lf_burst, sf_burst;
  logic [31:0]  reg_rdata, q;
  rhg_reg_req_t reg_req;
  rhg_word_t    rx_in, host_out;
  int           fail_count, check_count, ev_cnt[4];
  // reserved codes never appear in these tables
  int tab[4][6] = '{'{1, 2, 3, 4, 0, 0}, '{1, 4, 6, 8, 16, 32}, '{1, 4, 8, 0, 0, 0}, '{1, 4, 8, 0, 0, 0}};
  int sh[4] = '{3, 5, 8, 10};
  rhg_top u_rhg_top (.clock(clock), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .rx_in(rx_in), .rx_ready(rx_ready), .host_out(host_out), .pkt_abort(pkt_abort),
    .raw_buf_done(ev_in[0]), .raw_chain_post(ev_out[0]), .rdy_post(ev_in[1]), .lf_read(ev_in[2]),
    .sf_read(ev_in[3]), .lf_burst(lf_burst), .sf_burst(sf_burst), .ready_queue_irq(ev_out[1]),
    .large_free_queue_irq(ev_out[2]), .small_free_queue_irq(ev_out[3]));
  rhg_host u_rhg_host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    for (int j = 0; j < 4; j++) begin
      if (ev_out[j] === 1'b1) ev_cnt[j]++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'h0);
    u_rhg_host.acc(1'b1, a, d, be, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_rhg_host.acc(1'b0, a, 32'h0000_0000, 4'h0, q);
    chk(q, e);
  endtask : rd
  task automatic word(input logic [31:0] d, input logic s, input logic e, input logic [31:0] xd,
                      input logic xv, input logic xa);
    @(negedge clock);
    rx_in = '{valid: 1'b1, data: d, sop: s, eop: e};
    @(negedge clock);
    rx_in = '0;
    chk({host_out.valid, host_out.sop, host_out.eop, pkt_abort}, {xv, xv & s, xv & e, xa});
    if (xv) chk(host_out.data, xd);
  endtask : word
  // n pulses: no event until the last, exactly one after it
  task automatic evt(input int k, input int n);
    int c0;
    c0 = ev_cnt[k];
    for (int i = 1; i <= n; i++) begin
      @(negedge clock);
      ev_in[k] = 1'b1;
      @(negedge clock);
      ev_in[k] = 1'b0;
      repeat (3) @(negedge clock);
      chk(ev_cnt[k] - c0, (i == n));
    end
  endtask : evt
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #(5000 * 100);
    fail_count++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0;
    rx_in = '0;
    ev_in = 4'h0;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    rd(`RHG_OFF_HDLC_CFG, `RHG_CFG_RESET);
    rd(`RHG_OFF_MAX_LEN, `RHG_MAX_RESET);
    rd(`RHG_OFF_DMA_CTRL, `RHG_CTL_RESET);
    chk({lf_burst, sf_burst}, {2{`RHG_CACHE_BURST}});
    wr(`RHG_OFF_HDLC_CFG, 32'h0000_0307, 4'hF);
    rd(`RHG_OFF_HDLC_CFG, 32'h0000_0007);
    wr(`RHG_OFF_HDLC_CFG, 32'h0000_0307, 4'hE);
    rd(`RHG_OFF_HDLC_CFG, 32'h0000_0307);
    wr(12'h300, 32'hFFFF_FFFF);
    rd(12'h300, 32'h0000_0000);
    $display("test registers done");
    word(32'h0000_00A5, 1'b1, 1'b1, 32'h0, 1'b0, 1'b0);
    wr(`RHG_OFF_DMA_CTRL, 32'h0000_0001);
    chk({rx_ready, lf_burst, sf_burst}, 7'h49);
    wr(`RHG_OFF_MAX_LEN, 32'h0000_0008);
    word(32'h0102_0380, 1'b1, 1'b0, 32'h8040_C001, 1'b1, 1'b0);
    word(32'h0000_0001, 1'b0, 1'b0, 32'h0000_0080, 1'b1, 1'b0);
    word(32'h0000_0002, 1'b0, 1'b0, 32'h0, 1'b0, 1'b1);
    word(32'h0000_0003, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0);
    wr(`RHG_OFF_HDLC_CFG, 32'h0000_0007);
    wr(`RHG_OFF_MAX_LEN, 32'h0000_FFFF);
    word(32'h0102_0380, 1'b1, 1'b0, 32'h0102_0380, 1'b1, 1'b0);
    word(32'h0000_0011, 1'b0, 1'b0, 32'h0000_0011, 1'b1, 1'b0);
    word(32'h0000_0022, 1'b0, 1'b1, 32'h0000_0022, 1'b1, 1'b0);
    $display("test stream done");
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6 && tab[k][i] != 0; i++) begin
        wr(`RHG_OFF_DMA_CTRL, 32'h0000_0001 | (i << sh[k]));
        evt(k, tab[k][i]);
        evt(k, tab[k][i]);
      end
    end
    $display("test thresholds done");
    report_and_stop();
  end
endmodule : rhg_top_tb
